// file: mac_regs_pkg.sv
// Package for the station address table and DMA head pointer register bank.
// Assumes a 32-bit APB slave port with word-aligned byte addresses.
package mac_regs_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned NUM_ENTRIES  = 8;
	localparam int unsigned NUM_CHANNELS = 8;
	localparam int unsigned INDEX_W      = 3;
	localparam int unsigned ADDR_W       = 48;
	localparam int unsigned UPPER_W      = 40;
	localparam int unsigned PADDR_W      = 12;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_SELECT   = 12'h000;
	localparam logic [11:0] OFS_HIGH     = 12'h004;
	localparam logic [11:0] OFS_LOW      = 12'h008;
	localparam logic [11:0] OFS_STATUS   = 12'h00C;
	localparam logic [11:0] OFS_VALID    = 12'h010;
	localparam logic [11:0] OFS_TX_HEAD  = 12'h040;
	localparam logic [11:0] OFS_RX_HEAD  = 12'h060;
	localparam logic [11:0] HEAD_SPAN    = 12'h020;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned LOW_BYTE0_LSB  = 8;
	localparam int unsigned LOW_BYTE1_LSB  = 0;
	localparam int unsigned HIGH_BYTE2_LSB = 24;
	localparam int unsigned HIGH_BYTE3_LSB = 16;
	localparam int unsigned HIGH_BYTE4_LSB = 8;
	localparam int unsigned HIGH_BYTE5_LSB = 0;
	localparam int unsigned GROUP_BIT      = 40;
	localparam int unsigned GROUP_BIT_HIGH = 0;
	localparam int unsigned STAT_RX_LSB    = 8;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] HIGH_RESET  = 32'h0000_0000;
	localparam logic [31:0] HEAD_RESET  = 32'h0000_0000;
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] dest;
	} frame_dest_t;

	typedef struct packed {
		logic               valid;
		logic               hit;
		logic [INDEX_W-1:0] entry;
	} match_result_t;

endpackage

// file: station_match.sv
// Compares one destination address against the station address table.
// Assumes entries arrive already composed; purely combinational.
`timescale 1ns/1ps
module station_match #(
	parameter int unsigned ENTRIES = 8
) (
	input  wire logic [47:0]                    dest,
	input  wire logic [ENTRIES*48-1:0]          table_addr,
	input  wire logic [ENTRIES-1:0]             table_valid,
	output logic                                hit,
	output logic [$clog2(ENTRIES)-1:0]          entry
);

	// ----------------------------------------------------------------
	// Lowest matching entry wins
	// ----------------------------------------------------------------
	// Group addresses never hit: the table only holds unicast entries
	always_comb begin
		hit   = 1'b0;
		entry = '0;
		for (int i = ENTRIES - 1; i >= 0; i--) begin
			if (table_valid[i] && !dest[mac_regs_pkg::GROUP_BIT] &&
			    table_addr[i*48 +: 48] == dest) begin
				hit   = 1'b1;
				entry = i[$clog2(ENTRIES)-1:0];
			end
		end
	end

endmodule

// file: mac_addr_table_and_dma_heads.sv
// Station address table and per-channel DMA head pointer registers.
// Assumes an APB master on core_clk; frame addresses and DMA done strobes
// come from logic on the same clock.
//
// Operation
// - Incoming destination matched against programmed entries
// - Low register bits 15:8 hold byte zero
// - Low register bits 7:0 hold byte one
// - High register holds bytes two to five
// - Group bit forced and read as zero
// - Three-bit select picks entry for writes
// - Upper 40 bits shared, low byte per entry
// - Eight transmit and eight receive head pointers
// - Transmit head write starts transmit queue
// - Receive head write enables receive into buffers
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module mac_addr_table_and_dma_heads #(
	parameter int unsigned ENTRIES  = mac_regs_pkg::NUM_ENTRIES,
	parameter int unsigned CHANNELS = mac_regs_pkg::NUM_CHANNELS
) (
	input  wire logic                                core_clk,
	input  wire logic                                reset_n,
	// APB slave
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [mac_regs_pkg::PADDR_W-1:0]    paddr,
	input  wire logic [31:0]                         pwdata,
	output logic [31:0]                              prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	// Receive address filter
	input  wire mac_regs_pkg::frame_dest_t           frame_dest,
	output mac_regs_pkg::match_result_t              match_result,
	// DMA engine side
	input  wire logic [CHANNELS-1:0]                 tx_queue_done,
	input  wire logic [CHANNELS-1:0]                 rx_queue_done,
	output logic [CHANNELS-1:0]                      tx_queue_start,
	output logic [CHANNELS-1:0]                      rx_queue_enable,
	output logic [CHANNELS*32-1:0]                   tx_head_pointer,
	output logic [CHANNELS*32-1:0]                   rx_head_pointer
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Upper 40 address bits from high register and shared byte one
	function automatic logic [39:0] compose_upper(input logic [31:0] high, input logic [7:0] byte1);
		compose_upper = {high[7:0] & 8'hFE, high[15:8], high[23:16], high[31:24], byte1};
	endfunction

	// Channel number from a head pointer byte address
	function automatic logic [2:0] head_channel(input logic [11:0] addr);
		head_channel = addr[4:2];
	endfunction

	// Head pointer window hit
	function automatic logic in_window(input logic [11:0] addr, input logic [11:0] base);
		in_window = (addr >= base) && (addr < base + mac_regs_pkg::HEAD_SPAN) && (addr[1:0] == 2'b00);
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [2:0]          select_ff;
	logic [31:0]         high_ff;
	logic [7:0]          byte1_ff;
	logic [7:0]          byte0_ff [ENTRIES];
	logic [ENTRIES-1:0]  valid_ff;
	logic [31:0]         tx_head_ff [CHANNELS];
	logic [31:0]         rx_head_ff [CHANNELS];
	logic [CHANNELS-1:0] tx_err_ff;
	logic [CHANNELS-1:0] rx_err_ff;
	logic [CHANNELS-1:0] tx_start_ff;
	logic [31:0]         prdata_ff;
	logic                pready_ff;
	logic                pslverr_ff;
	mac_regs_pkg::match_result_t match_ff;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// One wait state so that read data can come from a flop
	wire        acc_first  = psel && penable && !pready_ff;
	wire        acc_commit = psel && penable && pready_ff;
	wire        wr_commit  = acc_commit && pwrite;
	wire        hit_select = (paddr == mac_regs_pkg::OFS_SELECT);
	wire        hit_high   = (paddr == mac_regs_pkg::OFS_HIGH);
	wire        hit_low    = (paddr == mac_regs_pkg::OFS_LOW);
	wire        hit_status = (paddr == mac_regs_pkg::OFS_STATUS);
	wire        hit_valid  = (paddr == mac_regs_pkg::OFS_VALID);
	wire        hit_tx     = in_window(paddr, mac_regs_pkg::OFS_TX_HEAD);
	wire        hit_rx     = in_window(paddr, mac_regs_pkg::OFS_RX_HEAD);
	wire        mapped     = hit_select | hit_high | hit_low | hit_status | hit_valid | hit_tx | hit_rx;
	wire [2:0]  chan       = head_channel(paddr);
	wire        wdata_zero = (pwdata == mac_regs_pkg::HEAD_RESET);

	// ----------------------------------------------------------------
	// Composed table
	// ----------------------------------------------------------------
	wire [39:0]          upper = compose_upper(high_ff, byte1_ff);
	logic [ENTRIES*48-1:0] table_flat;

	// Each entry is the shared upper part plus its own byte zero
	always_comb begin
		for (int i = 0; i < ENTRIES; i++) begin
			table_flat[i*48 +: 48] = {upper, byte0_ff[i]};
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	logic [31:0] read_value;

	always_comb begin
		read_value = mac_regs_pkg::READ_ZERO;
		if (hit_select) begin
			read_value[2:0] = select_ff;
		end else if (hit_high) begin
			read_value = {high_ff[31:1], 1'b0};
		end else if (hit_low) begin
			read_value[15:8] = byte0_ff[select_ff];
			read_value[7:0]  = byte1_ff;
		end else if (hit_status) begin
			read_value[7:0]  = tx_err_ff;
			read_value[15:8] = rx_err_ff;
		end else if (hit_valid) begin
			read_value[ENTRIES-1:0] = valid_ff;
		end else if (hit_tx) begin
			read_value = tx_head_ff[chan];
		end else if (hit_rx) begin
			read_value = rx_head_ff[chan];
		end
	end

	// ----------------------------------------------------------------
	// APB handshake
	// ----------------------------------------------------------------
	// Ready rises one cycle into the access phase and drops after commit
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= mac_regs_pkg::READ_ZERO;
		end else if (acc_first) begin
			pready_ff  <= 1'b1;
			pslverr_ff <= !mapped;
			prdata_ff  <= pwrite ? mac_regs_pkg::READ_ZERO : read_value;
		end else begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Address table registers
	// ----------------------------------------------------------------
	// Select is only three bits; the rest of the word is dropped
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			select_ff <= 3'b000;
			high_ff   <= mac_regs_pkg::HIGH_RESET;
		end else if (wr_commit && hit_select) begin
			select_ff <= pwdata[2:0];
		end else if (wr_commit && hit_high) begin
			high_ff <= {pwdata[31:1], 1'b0};
		end
	end

	// Low write stores shared byte one and this entry's byte zero
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			byte1_ff <= mac_regs_pkg::BYTE_RESET;
			valid_ff <= '0;
			for (int i = 0; i < ENTRIES; i++) begin
				byte0_ff[i] <= mac_regs_pkg::BYTE_RESET;
			end
		end else if (wr_commit && hit_low) begin
			byte1_ff            <= pwdata[7:0];
			byte0_ff[select_ff] <= pwdata[15:8];
			valid_ff[select_ff] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Receive address matching
	// ----------------------------------------------------------------
	localparam int unsigned INDEX_W_L = $clog2(ENTRIES);
	logic                   cmp_hit;
	logic [INDEX_W_L-1:0]   cmp_entry;

	station_match #(
		.ENTRIES     (ENTRIES)
	) u_match (
		.dest        (frame_dest.dest),
		.table_addr  (table_flat),
		.table_valid (valid_ff),
		.hit         (cmp_hit),
		.entry       (cmp_entry)
	);

	// Registered so the result leaves on a flop
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			match_ff <= '0;
		end else begin
			match_ff.valid <= frame_dest.valid;
			match_ff.hit   <= frame_dest.valid && cmp_hit;
			match_ff.entry <= cmp_entry;
		end
	end

	// ----------------------------------------------------------------
	// Head pointers
	// ----------------------------------------------------------------
	// A write to a busy pointer is refused and flagged; zero always clears
	wire tx_wr = wr_commit && hit_tx;
	wire rx_wr = wr_commit && hit_rx;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_start_ff <= '0;
			for (int i = 0; i < CHANNELS; i++) begin
				tx_head_ff[i] <= mac_regs_pkg::HEAD_RESET;
				rx_head_ff[i] <= mac_regs_pkg::HEAD_RESET;
			end
		end else begin
			tx_start_ff <= '0;
			for (int i = 0; i < CHANNELS; i++) begin
				if (tx_wr && chan == i[2:0] && (wdata_zero || tx_head_ff[i] == mac_regs_pkg::HEAD_RESET)) begin
					tx_head_ff[i]  <= pwdata;
					tx_start_ff[i] <= !wdata_zero;
				end else if (tx_queue_done[i]) begin
					tx_head_ff[i] <= mac_regs_pkg::HEAD_RESET;
				end
				if (rx_wr && chan == i[2:0] && (wdata_zero || rx_head_ff[i] == mac_regs_pkg::HEAD_RESET)) begin
					rx_head_ff[i] <= pwdata;
				end else if (rx_queue_done[i]) begin
					rx_head_ff[i] <= mac_regs_pkg::HEAD_RESET;
				end
			end
		end
	end

	// Error flags: set wins over a write-one clear in the same cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_err_ff <= '0;
			rx_err_ff <= '0;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (tx_wr && chan == i[2:0] && !wdata_zero && tx_head_ff[i] != mac_regs_pkg::HEAD_RESET) begin
					tx_err_ff[i] <= 1'b1;
				end else if (wr_commit && hit_status && pwdata[i]) begin
					tx_err_ff[i] <= 1'b0;
				end
				if (rx_wr && chan == i[2:0] && !wdata_zero && rx_head_ff[i] != mac_regs_pkg::HEAD_RESET) begin
					rx_err_ff[i] <= 1'b1;
				end else if (wr_commit && hit_status && pwdata[mac_regs_pkg::STAT_RX_LSB + i]) begin
					rx_err_ff[i] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic [CHANNELS-1:0]    rx_enable_ff;
	logic [CHANNELS*32-1:0] tx_flat_ff;
	logic [CHANNELS*32-1:0] rx_flat_ff;

	// Flat copies keep every output on a flop, one cycle behind the array
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_enable_ff <= '0;
			tx_flat_ff   <= '0;
			rx_flat_ff   <= '0;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				rx_enable_ff[i]        <= (rx_head_ff[i] != mac_regs_pkg::HEAD_RESET);
				tx_flat_ff[i*32 +: 32] <= tx_head_ff[i];
				rx_flat_ff[i*32 +: 32] <= rx_head_ff[i];
			end
		end
	end

	assign prdata          = prdata_ff;
	assign pready          = pready_ff;
	assign pslverr         = pslverr_ff;
	assign match_result    = match_ff;
	assign tx_queue_start  = tx_start_ff;
	assign rx_queue_enable = rx_enable_ff;
	assign tx_head_pointer = tx_flat_ff;
	assign rx_head_pointer = rx_flat_ff;

endmodule

// file: mac_regs_assertions.sv
// Port checker for the station table and head pointer register bank.
// Assumes one clock domain and binding to the top module.
`timescale 1ns/1ps
module mac_regs_assertions #(
	parameter int unsigned CHANNELS = 8
) (
	input wire logic                        core_clk,
	input wire logic                        reset_n,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [11:0]                 paddr,
	input wire logic [31:0]                 prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire mac_regs_pkg::frame_dest_t   frame_dest,
	input wire mac_regs_pkg::match_result_t match_result,
	input wire logic [CHANNELS-1:0]         tx_queue_start,
	input wire logic [CHANNELS-1:0]         rx_queue_enable,
	input wire logic [CHANNELS*32-1:0]      tx_head_pointer,
	input wire logic [CHANNELS*32-1:0]      rx_head_pointer
);
	logic [CHANNELS-1:0] tx_nz;
	logic [CHANNELS-1:0] rx_nz;
	wire                 rd_ok = pready && !pwrite && !pslverr;

	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	// Nonzero lanes of the pointer buses
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			tx_nz[i] = |tx_head_pointer[i*32+:32];
			rx_nz[i] = |rx_head_pointer[i*32+:32];
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	one_wait_a: assert property (psel && $rose(penable) |=> pready)
		else $error("ready not one cycle after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held two cycles");
	bad_read_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0000_0000))
		else $error("error response malformed");
	group_read_a: assert property (rd_ok && paddr == mac_regs_pkg::OFS_HIGH |-> !prdata[0])
		else $error("group bit read as one");
	low_rsvd_a: assert property (rd_ok && paddr == mac_regs_pkg::OFS_LOW |-> prdata[31:16] == 16'h0000)
		else $error("low reserved bits set");
	select_rsvd_a: assert property (rd_ok && paddr == mac_regs_pkg::OFS_SELECT |-> prdata[31:3] == 29'h0000_0000)
		else $error("select reserved bits set");
	match_timing_a: assert property (match_result.valid == $past(frame_dest.valid))
		else $error("match result not one cycle after frame");
	group_nohit_a: assert property (frame_dest.valid && frame_dest.dest[40] |=> !match_result.hit)
		else $error("group address matched");
	// Pointer bus lags the start pulse by one cycle, so nonzero is checked a cycle on
	tx_start_a: assert property (|tx_queue_start |-> $past(psel && penable && pready && pwrite)
		##1 (tx_queue_start == '0 && ($past(tx_queue_start) & ~tx_nz) == '0))
		else $error("transmit start without write");
	rx_enable_a: assert property (rx_queue_enable == rx_nz)
		else $error("receive enable not tied to pointer");
endmodule

bind mac_addr_table_and_dma_heads mac_regs_assertions #(.CHANNELS(CHANNELS)) u_chk (
	.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_dest(frame_dest),
	.match_result(match_result), .tx_queue_start(tx_queue_start), .rx_queue_enable(rx_queue_enable),
	.tx_head_pointer(tx_head_pointer), .rx_head_pointer(rx_head_pointer)
);

// file: testbench.sv
// Self-checking bench for the station table and head pointer bank.
// Assumes the bound checker; bench acts as APB master and DMA side.
`timescale 1ns/1ps
module testbench;
	logic                        core_clk = 1'b0;
	logic                        reset_n, psel, penable, pwrite, pready, pslverr, err_v;
	logic [11:0]                 paddr, a;
	logic [31:0]                 pwdata, prdata, rd_v, high_v, v;
	logic [7:0]                  tx_queue_done, rx_queue_done, tx_queue_start, rx_queue_enable, byte1_v;
	logic [7:0]                  byte0_q [8];
	logic [255:0]                tx_head_pointer, rx_head_pointer;
	mac_regs_pkg::frame_dest_t   frame_dest;
	mac_regs_pkg::match_result_t match_result;
	int                          bad_count = 0, cmp_count = 0, seed = 13, ch, rx;

	always #25 core_clk = ~core_clk;

	mac_addr_table_and_dma_heads DUT (
		.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.frame_dest(frame_dest), .match_result(match_result), .tx_queue_done(tx_queue_done),
		.rx_queue_done(rx_queue_done), .tx_queue_start(tx_queue_start), .rx_queue_enable(rx_queue_enable),
		.tx_head_pointer(tx_head_pointer), .rx_head_pointer(rx_head_pointer)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic complete_run;
		if (bad_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; a cap on the wait catches a hung slave
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge core_clk);
		psel <= 1'b1; pwrite <= wr; paddr <= ad; pwdata <= d; penable <= 1'b0;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			bad_count++;
			complete_run;
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d, rd_v, err_v);
	endtask

	task automatic rdc(input logic [11:0] ad, input logic [31:0] e);
		apb(1'b0, ad, 32'h0000_0000, rd_v, err_v);
		chk(rd_v, e);
	endtask

	// Frame address in, result one cycle later; entry ignored on a miss
	task automatic send(input logic [47:0] d, input logic h, input logic [2:0] e);
		@(posedge core_clk);
		frame_dest <= {1'b1, d};
		@(posedge core_clk);
		frame_dest.valid <= 1'b0;
		@(posedge core_clk);
		chk({match_result.valid, match_result.hit, h ? match_result.entry : 3'h0}, {1'b1, h, e});
	endtask

	function automatic logic [47:0] exp_dest(input logic [31:0] h, input logic [7:0] b1, input logic [7:0] b0);
		return {h[7:1], 1'b0, h[15:8], h[23:16], h[31:24], b1, b0};
	endfunction

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
		frame_dest = '0; tx_queue_done = '0; rx_queue_done = '0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		rdc(mac_regs_pkg::OFS_HIGH, mac_regs_pkg::HIGH_RESET);
		rdc(mac_regs_pkg::OFS_VALID, 32'h0000_0000);
		apb(1'b0, 12'h0FC, 32'h0000_0000, rd_v, err_v);
		chk({rd_v[30:0], err_v}, 32'h0000_0001);
		high_v = $random(seed) | 32'h0000_0001;
		wr(mac_regs_pkg::OFS_SELECT, 32'h0000_0000);
		wr(mac_regs_pkg::OFS_HIGH, high_v);
		rdc(mac_regs_pkg::OFS_HIGH, high_v & 32'hFFFF_FFFE);
		byte1_v = 8'($random(seed));
		// Distinct low bytes so the lowest-match choice is unambiguous
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			byte0_q[i] = {v[7:3], i[2:0]};
			wr(mac_regs_pkg::OFS_SELECT, v ^ i);
			rdc(mac_regs_pkg::OFS_SELECT, {29'h0000_0000, v[2:0] ^ i[2:0]});
			wr(mac_regs_pkg::OFS_SELECT, {v[31:3], i[2:0]});
			wr(mac_regs_pkg::OFS_LOW, {16'h0000, byte0_q[i], byte1_v});
			rdc(mac_regs_pkg::OFS_LOW, {16'h0000, byte0_q[i], byte1_v});
		end
		rdc(mac_regs_pkg::OFS_VALID, 32'h0000_00FF);
		for (int i = 0; i < 8; i++)
			send(exp_dest(high_v, byte1_v, byte0_q[i]), 1'b1, i[2:0]);
		send(exp_dest(high_v, byte1_v, byte0_q[2]) | 48'h0100_0000_0000, 1'b0, 3'h0);
		send(exp_dest(high_v ^ 32'h0100_0000, byte1_v, byte0_q[0]), 1'b0, 3'h0);
		high_v = high_v ^ 32'h00FF_0000;
		wr(mac_regs_pkg::OFS_HIGH, high_v);
		send(exp_dest(high_v, byte1_v, byte0_q[5]), 1'b1, 3'h5);
		// Clear all heads as software must after reset
		for (int k = 0; k < 16; k++)
			wr((k < 8 ? mac_regs_pkg::OFS_TX_HEAD : mac_regs_pkg::OFS_RX_HEAD) + 12'(4 * (k % 8)), 0);
		// Start, refused rewrite, error flag, done clear per channel
		for (int k = 0; k < 16; k++) begin
			ch = k % 8;
			rx = k / 8;
			a = (rx == 1 ? mac_regs_pkg::OFS_RX_HEAD : mac_regs_pkg::OFS_TX_HEAD) + 12'(4 * ch);
			v = $random(seed) | 32'h0000_0001;
			wr(a, v);
			// Start pulse stands one cycle; pointer and enable flops lag one more
			@(posedge core_clk);
			chk({31'h0000_0000, tx_queue_start[ch]}, 32'(rx == 0));
			@(posedge core_clk);
			chk({31'h0000_0000, rx == 1 ? rx_queue_enable[ch] : tx_queue_start[ch]}, 32'(rx == 1));
			chk(rx == 1 ? rx_head_pointer[ch*32+:32] : tx_head_pointer[ch*32+:32], v);
			wr(a, ~v | 32'h0000_0002);
			rdc(a, v);
			rdc(mac_regs_pkg::OFS_STATUS, 32'h0000_0001 << (ch + 8 * rx));
			wr(mac_regs_pkg::OFS_STATUS, 32'hFFFF_FFFF);
			@(posedge core_clk);
			if (rx == 1)
				rx_queue_done[ch] <= 1'b1;
			else
				tx_queue_done[ch] <= 1'b1;
			@(posedge core_clk);
			rx_queue_done <= '0;
			tx_queue_done <= '0;
			rdc(a, 32'h0000_0000);
		end
		complete_run;
	end
endmodule
